//--- hdl/scsq_pkg.sv
// Package with constants, enums and structs of the spectral conversion sequencer.
package scsq_pkg;

  // Wishbone register byte offsets.
  localparam logic [7:0] SCSQ_OFF_CTRL   = 8'h00;
  localparam logic [7:0] SCSQ_OFF_ITIME  = 8'h04;
  localparam logic [7:0] SCSQ_OFF_STATUS = 8'h08;
  localparam logic [7:0] SCSQ_OFF_LED    = 8'h0C;
  localparam logic [7:0] SCSQ_OFF_TEMP   = 8'h10;
  localparam logic [7:0] SCSQ_OFF_DATA0  = 8'h20;

  // Control field positions.
  localparam int SCSQ_CTRL_RUN_BIT  = 0;
  localparam int SCSQ_CTRL_IEN_BIT  = 1;
  localparam int SCSQ_CTRL_MODE_LSB = 2;
  localparam int SCSQ_CTRL_FWUP_BIT = 4;
  localparam int SCSQ_LED_EN_BIT    = 2;

  // Reset values.
  localparam logic [1:0]  SCSQ_MODE_RST  = 2'h0;
  localparam logic [23:0] SCSQ_ITIME_RST = 24'h00AFC8;

  // Timing.
  localparam int SCSQ_CLK_MHZ     = 100;
  localparam int SCSQ_ITIME_MIN_US = 2800;
  localparam logic [23:0] SCSQ_ITIME_MIN_CYC = 24'(SCSQ_ITIME_MIN_US * SCSQ_CLK_MHZ);
  localparam int SCSQ_RST_MIN_MS  = 100;
  localparam int SCSQ_RST_MIN_CYC = SCSQ_RST_MIN_MS * 1000 * SCSQ_CLK_MHZ + 1;
  localparam int SCSQ_BLINK_CYC   = 25000000;

  // Group modes.
  typedef enum logic [1:0] {
    SCSQ_MODE_G0,
    SCSQ_MODE_G1,
    SCSQ_MODE_BOTH
  } scsq_mode_e;

  // Converter sample presented to one channel.
  typedef struct packed {
    logic [15:0] value;
    logic        valid;
  } scsq_sample_s;

  // Indicator sink setting.
  typedef struct packed {
    logic       enable;
    logic [1:0] level;
  } scsq_led_s;

endpackage : scsq_pkg

//--- hdl/scsq_sync3.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
module scsq_sync3 (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic rst_val_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // The output only changes when the second and third stages agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= rst_val_i;
      s2_r <= rst_val_i;
      s3_r <= rst_val_i;
      q_o  <= rst_val_i;
    end else if (ce_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_o <= s3_r;
      end
    end
  end
endmodule : scsq_sync3

//--- hdl/scsq_top.sv
// Spectral conversion sequencer with Wishbone registers.
`timescale 1ns/100ps
module scsq_top
  import scsq_pkg::*;
#(
  parameter int RST_MIN_CYC   = SCSQ_RST_MIN_CYC,
  parameter int BLINK_CYC     = SCSQ_BLINK_CYC,
  // Shortest period in clock cycles; smaller period settings are raised to it.
  parameter int ITIME_MIN_CYC = int'(SCSQ_ITIME_MIN_CYC)
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  input  wire scsq_sample_s adc_sample_i,
  input  wire logic [15:0]  temp_sample_i,
  input  wire logic         external_reset_input_n_i,
  output logic [2:0]        adc_chan_o,
  output logic              adc_start_o,
  output logic              int_n_o,
  output logic              core_reset_o,
  output logic              second_reset_n_o,
  output logic [3:0]        indicator_led_sink_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INTEG,
    ST_FETCH
  } scsq_state_e;

  // Channel index per group: group A = ch 1,2,3,4; group B = ch 0,2,3,5.
  localparam logic [5:0] GRP_A_MASK = 6'h1E;
  localparam logic [5:0] GRP_B_MASK = 6'h2D;
  localparam logic [5:0] ALL_MASK   = 6'h3F;

  logic        run_r;
  logic        ien_r;
  logic        fwup_r;
  logic [1:0]  mode_r;
  logic [23:0] itime_r;
  scsq_led_s   led_r;
  logic [1:0]  cyc_mode_r;
  logic        grp_b_r;
  scsq_state_e state_r;
  logic [23:0] tick_r;
  logic [2:0]  ch_r;
  logic [15:0] work_r [6];
  logic [15:0] out_r  [6];
  logic [5:0]  work_mask_r;
  logic        rdy_r;
  logic        hold_r;
  logic        pend_r;
  logic [15:0] temp_r;
  logic        rst_pin_q;
  logic [31:0] rst_cnt_r;
  logic [31:0] blink_cnt_r;
  logic        blink_r;
  logic        wb_req;
  logic        wb_wr;
  logic        wb_rd;
  logic        data_rd;
  logic        cycle_done;
  logic [23:0] itime_eff;
  logic [2:0]  data_idx;

  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr      = wb_req & wb_we_i;
  assign wb_rd      = wb_req & ~wb_we_i;
  assign data_idx   = 3'((wb_adr_i - SCSQ_OFF_DATA0) >> 2);
  assign data_rd    = wb_rd && wb_adr_i >= SCSQ_OFF_DATA0 && wb_adr_i < 8'h38;
  // Short periods are clamped; the converter cannot settle faster.
  assign itime_eff  = (itime_r < 24'(ITIME_MIN_CYC)) ? 24'(ITIME_MIN_CYC) : itime_r;
  assign cycle_done = (state_r == ST_FETCH) && (ch_r == 3'd5) && (grp_b_r || cyc_mode_r != 2'd2);

  // Reset pin filter.
  scsq_sync3 u_rst_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .rst_val_i (1'b1),
    .d_i       (external_reset_input_n_i),
    .q_o       (rst_pin_q)
  );

  // Long-low detector: a low held past the minimum resets the core and the second device.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_cnt_r        <= 32'h0;
      core_reset_o     <= 1'b0;
      second_reset_n_o <= 1'b1;
    end else if (ce_i) begin
      // The second device trails the core by one cycle for as long as the core is held.
      second_reset_n_o <= ~core_reset_o;
      if (rst_pin_q) begin
        rst_cnt_r    <= 32'h0;
        core_reset_o <= 1'b0;
      end else if (rst_cnt_r < 32'(RST_MIN_CYC)) begin
        rst_cnt_r <= rst_cnt_r + 32'h1;
      end else begin
        core_reset_o <= 1'b1;
      end
    end
  end

  // Register writes from the host.
  always_ff @(posedge clk_i) begin
    if (rst_i || core_reset_o) begin
      run_r   <= 1'b0;
      ien_r   <= 1'b0;
      fwup_r  <= 1'b0;
      mode_r  <= SCSQ_MODE_RST;
      itime_r <= SCSQ_ITIME_RST;
      led_r   <= '0;
    end else if (ce_i && wb_wr) begin
      case (wb_adr_i)
        SCSQ_OFF_CTRL: begin
          if (wb_sel_i[0]) begin
            run_r  <= wb_dat_i[SCSQ_CTRL_RUN_BIT];
            ien_r  <= wb_dat_i[SCSQ_CTRL_IEN_BIT];
            mode_r <= wb_dat_i[SCSQ_CTRL_MODE_LSB +: 2];
            fwup_r <= wb_dat_i[SCSQ_CTRL_FWUP_BIT];
          end
        end
        SCSQ_OFF_ITIME: begin
          for (int b = 0; b < 3; b++) begin
            if (wb_sel_i[b]) begin
              itime_r[8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
          end
        end
        SCSQ_OFF_LED: begin
          if (wb_sel_i[0]) begin
            led_r <= wb_dat_i[2:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Conversion sequencer: integrate, then fetch six channels from the converter.
  always_ff @(posedge clk_i) begin
    if (rst_i || core_reset_o) begin
      state_r     <= ST_IDLE;
      tick_r      <= 24'h0;
      ch_r        <= 3'd0;
      grp_b_r     <= 1'b0;
      cyc_mode_r  <= 2'd0;
      adc_start_o <= 1'b0;
      adc_chan_o  <= 3'd0;
      work_mask_r <= 6'h0;
    end else if (ce_i) begin
      adc_start_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (run_r) begin
            cyc_mode_r  <= (mode_r == 2'd3) ? 2'd2 : mode_r;
            grp_b_r     <= (mode_r == 2'd1);
            work_mask_r <= 6'h0;
            tick_r      <= 24'h0;
            state_r     <= ST_INTEG;
          end
        end
        ST_INTEG: begin
          if (tick_r >= itime_eff - 24'h1) begin
            tick_r      <= 24'h0;
            ch_r        <= 3'd0;
            adc_chan_o  <= 3'd0;
            adc_start_o <= 1'b1;
            state_r     <= ST_FETCH;
          end else begin
            tick_r <= tick_r + 24'h1;
          end
        end
        ST_FETCH: begin
          if (adc_sample_i.valid) begin
            work_mask_r <= work_mask_r | (grp_b_r ? GRP_B_MASK : GRP_A_MASK);
            if (ch_r == 3'd5) begin
              if (cyc_mode_r == 2'd2 && !grp_b_r) begin
                grp_b_r <= 1'b1;
                state_r <= ST_INTEG;
              end else begin
                // Mode is resampled here and on leaving idle, so a change lands next cycle.
                cyc_mode_r  <= (mode_r == 2'd3) ? 2'd2 : mode_r;
                grp_b_r     <= (mode_r == 2'd1);
                work_mask_r <= 6'h0;
                state_r     <= run_r ? ST_INTEG : ST_IDLE;
              end
            end else begin
              ch_r        <= ch_r + 3'd1;
              adc_chan_o  <= ch_r + 3'd1;
              adc_start_o <= 1'b1;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Working buffer: channels of the groups fetched so far in the cycle, others zero.
  always_ff @(posedge clk_i) begin
    if (rst_i || core_reset_o) begin
      for (int i = 0; i < 6; i++) begin
        work_r[i] <= 16'h0;
      end
    end else if (ce_i && state_r == ST_FETCH && adc_sample_i.valid) begin
      if ((grp_b_r ? GRP_B_MASK[ch_r] : GRP_A_MASK[ch_r])) begin
        work_r[ch_r] <= adc_sample_i.value;
      end else if (!work_mask_r[ch_r] || cyc_mode_r != 2'd2) begin
        work_r[ch_r] <= 16'h0;
      end
    end
  end

  // Output buffer: whole-cycle copy, deferred while a value is being read.
  always_ff @(posedge clk_i) begin
    if (rst_i || core_reset_o) begin
      for (int i = 0; i < 6; i++) begin
        out_r[i] <= 16'h0;
      end
      pend_r <= 1'b0;
    end else if (ce_i) begin
      if ((cycle_done && adc_sample_i.valid && hold_r) || (pend_r && hold_r)) begin
        pend_r <= 1'b1;
      end else if (pend_r) begin
        out_r  <= work_r;
        pend_r <= 1'b0;
      end else if (cycle_done && adc_sample_i.valid) begin
        out_r <= work_r;
        out_r[5] <= (grp_b_r ? GRP_B_MASK[5] : GRP_A_MASK[5]) ? adc_sample_i.value : 16'h0;
      end
    end
  end

  // Partial-read hold: a lower-byte access locks the buffer until the top byte is read.
  always_ff @(posedge clk_i) begin
    if (rst_i || core_reset_o) begin
      hold_r <= 1'b0;
    end else if (ce_i && data_rd) begin
      hold_r <= !wb_sel_i[1] && wb_sel_i[0];
    end
  end

  // Data ready and interrupt pin; a new result beats a same-cycle read clear.
  always_ff @(posedge clk_i) begin
    if (rst_i || core_reset_o) begin
      rdy_r   <= 1'b0;
      int_n_o <= 1'b1;
    end else if (ce_i) begin
      if (cycle_done && adc_sample_i.valid) begin
        rdy_r   <= 1'b1;
        int_n_o <= ~ien_r;
      end else if (data_rd) begin
        rdy_r   <= 1'b0;
        int_n_o <= 1'b1;
      end
    end
  end

  // Temperature is captured every cycle regardless of run state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_r <= 16'h0;
    end else if (ce_i) begin
      temp_r <= temp_sample_i;
    end
  end

  // Indicator sink: host setting, overridden by a blink during firmware update.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_r          <= 32'h0;
      blink_r              <= 1'b0;
      indicator_led_sink_o <= 4'h0;
    end else if (ce_i) begin
      if (fwup_r && blink_cnt_r < 32'(BLINK_CYC) - 32'h1) begin
        blink_cnt_r <= blink_cnt_r + 32'h1;
      end else begin
        blink_cnt_r <= 32'h0;
        blink_r     <= fwup_r & ~blink_r;
      end
      if (fwup_r) begin
        indicator_led_sink_o <= blink_r ? 4'h1 : 4'h0;
      end else begin
        indicator_led_sink_o <= led_r.enable ? (4'h1 << led_r.level) : 4'h0;
      end
    end
  end

  // Wishbone answer: one wait-free ack per request, unmapped reads return zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_rd) begin
        if (data_rd) begin
          wb_dat_o <= {16'h0, out_r[data_idx]};
        end else begin
          case (wb_adr_i)
            SCSQ_OFF_CTRL:   wb_dat_o <= {27'h0, fwup_r, mode_r, ien_r, run_r};
            SCSQ_OFF_ITIME:  wb_dat_o <= {8'h0, itime_r};
            SCSQ_OFF_STATUS: wb_dat_o <= {28'h0, grp_b_r, state_r != ST_IDLE, ~int_n_o, rdy_r};
            SCSQ_OFF_LED:    wb_dat_o <= {29'h0, led_r};
            SCSQ_OFF_TEMP:   wb_dat_o <= {16'h0, temp_r};
            default:         wb_dat_o <= 32'h0;
          endcase
        end
      end
    end
  end

endmodule : scsq_top

//--- tb/scsq_top_asserts.sv
// Concurrent checks on the ports of the spectral conversion sequencer.
`timescale 1ns/100ps
module scsq_top_asserts
  import scsq_pkg::*;
#(
  parameter int RST_MIN_CYC = SCSQ_RST_MIN_CYC
) (
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         ce_i,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_ack_o,
  input wire scsq_sample_s adc_sample_i,
  input wire logic [2:0]   adc_chan_o,
  input wire logic         adc_start_o,
  input wire logic         int_n_o,
  input wire logic         core_reset_o,
  input wire logic         second_reset_n_o,
  input wire logic         external_reset_input_n_i,
  input wire logic [3:0]   indicator_led_sink_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  int low_cnt;

  // Raw pin low time; the filter delay only makes the real figure larger.
  always_ff @(posedge clk_i) begin
    low_cnt <= external_reset_input_n_i ? 0 : low_cnt + 1;
  end

  // A bus request that the slave must take on this edge.
  sequence s_req_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  // The primary core enters reset.
  sequence s_core_up;
    $rose(core_reset_o);
  endsequence

  a_ack_after_req: assert property (s_req_taken |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_unasked: assert property (!wb_stb_i |=> !wb_ack_o)
    else $error("ack without request");
  a_start_pulse: assert property (adc_start_o |=> !adc_start_o)
    else $error("start longer than one cycle");
  a_chan_range: assert property (adc_chan_o <= 3'h5)
    else $error("channel out of range");
  a_chan_holds: assert property (adc_start_o && !adc_sample_i.valid |=> $stable(adc_chan_o))
    else $error("channel moved before answer");
  a_next_start: assert property (adc_sample_i.valid && adc_chan_o != 3'h5 |=> adc_start_o)
    else $error("no start after answer");
  a_core_needs_low: assert property (s_core_up |-> low_cnt >= RST_MIN_CYC)
    else $error("core reset after short pulse");
  a_second_enter: assert property (s_core_up |=> !second_reset_n_o)
    else $error("second device not reset");
  a_second_leave: assert property ($fell(core_reset_o) |=> second_reset_n_o)
    else $error("second device held in reset");
  a_core_release: assert property (external_reset_input_n_i [*6] |=> !core_reset_o)
    else $error("core reset stuck after pin release");
  a_int_holds: assert property (!int_n_o && !wb_cyc_i && !$past(wb_ack_o) && !core_reset_o
    |=> !int_n_o)
    else $error("interrupt released without access");
  a_sink_onehot: assert property ($onehot0(indicator_led_sink_o))
    else $error("sink level not one-hot");
endmodule : scsq_top_asserts

bind scsq_top scsq_top_asserts #(
  .RST_MIN_CYC(RST_MIN_CYC)
) i_scsq_top_asserts (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .adc_sample_i(adc_sample_i),
  .adc_chan_o(adc_chan_o),
  .adc_start_o(adc_start_o),
  .int_n_o(int_n_o),
  .core_reset_o(core_reset_o),
  .second_reset_n_o(second_reset_n_o),
  .external_reset_input_n_i(external_reset_input_n_i),
  .indicator_led_sink_o(indicator_led_sink_o)
);

//--- tb/scsq_adc_model.sv
// Behavioural converter that answers each start pulse after a chosen delay.
`timescale 1ns/100ps
module scsq_adc_model
  import scsq_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [2:0] chan_i,
  input  wire logic [3:0] delay_i,
  output scsq_sample_s    sample_o
);
  logic [3:0]  wait_r = 4'h0;
  logic        busy_r = 1'b0;
  logic [15:0] last_r = 16'h0000;

  // Between answers the bus shows the inverse of the last word, so stale data cannot pass.
  always @(posedge clk_i) begin
    sample_o.valid <= 1'b0;
    sample_o.value <= ~last_r;
    if (start_i) begin
      busy_r <= 1'b1;
      wait_r <= delay_i;
    end else if (busy_r && wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end else if (busy_r) begin
      busy_r         <= 1'b0;
      sample_o.valid <= 1'b1;
      sample_o.value <= {8'hA5, 5'h00, chan_i};
      last_r         <= {8'hA5, 5'h00, chan_i};
    end
  end
endmodule : scsq_adc_model

//--- tb/tb_top.sv
// Self-checking bench for the spectral conversion sequencer.
`timescale 1ns/100ps
module tb_top
  import scsq_pkg::*;
;
  // A short period floor keeps the run brief; the design raises period writes to it.
  localparam int PER         = 400;
  localparam int TIMEOUT_CYC = 20000;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         we = 1'b0;
  logic         pin_n = 1'b1;
  logic         ce = 1'b1;
  logic [3:0]   sel = 4'hF;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  dat = 32'h0;
  logic [31:0]  rd, rdat;
  logic [15:0]  temp = 16'h1A5C;
  logic [3:0]   dly = 4'h0;
  logic         ack, start, int_n, core_rst, sec_rst_n;
  logic [2:0]   chan;
  logic [3:0]   sink;
  scsq_sample_s smp;
  int           failures = 0;
  int           checks_done = 0;
  int           cyc_cnt = 0;

  // Device under test with short reset and blink counts.
  scsq_top #(.RST_MIN_CYC(20), .BLINK_CYC(4), .ITIME_MIN_CYC(PER)) i_scsq_top (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .adc_sample_i(smp), .temp_sample_i(temp),
    .external_reset_input_n_i(pin_n), .adc_chan_o(chan), .adc_start_o(start),
    .int_n_o(int_n), .core_reset_o(core_rst), .second_reset_n_o(sec_rst_n),
    .indicator_led_sink_o(sink));
  // Converter on the far side of the sampling interface.
  scsq_adc_model i_scsq_adc_model (
    .clk_i(clk_i), .start_i(start), .chan_i(chan), .delay_i(dly), .sample_o(smp));

  // Clock and hang guard.
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == TIMEOUT_CYC) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  // Classic single cycle; waits for ack with no assumed latency.
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rdat = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb_xfer

  task automatic wb_rd(input logic [7:0] a, input logic [31:0] exp);
    wb_xfer(1'b0, a, 32'h0);
    chk32(rdat, exp);
  endtask : wb_rd

  task automatic t_reset_values();
    wb_rd(SCSQ_OFF_CTRL, 32'h0);
    wb_rd(SCSQ_OFF_ITIME, 32'h00AFC8);
    wb_rd(SCSQ_OFF_LED, 32'h0);
    wb_rd(8'hFC, 32'h0);
    chk32({int_n, sec_rst_n, core_rst, sink}, 7'h60);
  endtask : t_reset_values

  // A short low pulse is ignored, a long one resets both devices in turn.
  task automatic t_ext_reset();
    logic seen;
    seen = 1'b0;
    pin_n <= 1'b0;
    repeat (10) @(posedge clk_i);
    pin_n <= 1'b1;
    repeat (20) @(posedge clk_i) seen |= core_rst;
    chk32(32'(seen), 32'h0);
    pin_n <= 1'b0;
    for (int n = 0; n < 60 && core_rst !== 1'b1; n++) @(posedge clk_i);
    chk32(32'(core_rst), 32'h1);
    @(posedge clk_i);
    chk32(32'(sec_rst_n), 32'h0);
    pin_n <= 1'b1;
    repeat (12) @(posedge clk_i);
  endtask : t_ext_reset

  task automatic t_led();
    for (int l = 0; l < 4; l++) begin
      wb_xfer(1'b1, SCSQ_OFF_LED, 32'(4 + l));
      repeat (2) @(posedge clk_i);
      chk32(32'(sink), 32'(1 << l));
    end
    wb_xfer(1'b1, SCSQ_OFF_LED, 32'h3);
    repeat (2) @(posedge clk_i);
    chk32(32'(sink), 32'h0);
  endtask : t_led

  // Update activity must toggle the sink with no host writes to it.
  task automatic t_blink();
    int n;
    logic [3:0] prev;
    n = 0;
    wb_xfer(1'b1, SCSQ_OFF_CTRL, 32'h10);
    prev = sink;
    repeat (24) @(posedge clk_i) begin
      n += int'(sink !== prev);
      prev = sink;
    end
    chk32(32'(n >= 2), 32'h1);
    // Clock enable low must freeze the blink, so the sink stands still.
    ce <= 1'b0;
    @(posedge clk_i);
    prev = sink;
    n    = 0;
    repeat (12) @(posedge clk_i) n += int'(sink !== prev);
    chk32(32'(n), 32'h0);
    ce <= 1'b1;
    wb_xfer(1'b1, SCSQ_OFF_CTRL, 32'h0);
  endtask : t_blink

  task automatic t_temp();
    wb_rd(SCSQ_OFF_TEMP, 32'h1A5C);
    temp <= 16'h2B6D;
    repeat (4) @(posedge clk_i);
    wb_rd(SCSQ_OFF_TEMP, 32'h2B6D);
  endtask : t_temp

  // A period below the floor is raised; data ready time and channel masks are judged.
  task automatic t_convert(input logic [31:0] ctl, input logic [5:0] mask, input int np);
    int t0;
    wb_xfer(1'b1, SCSQ_OFF_ITIME, 32'h1);
    wb_xfer(1'b1, SCSQ_OFF_CTRL, ctl);
    t0 = cyc_cnt;
    while (int_n !== 1'b0) @(posedge clk_i);
    t0 = cyc_cnt - t0;
    chk32(32'(t0 >= np * PER && t0 < np * PER + 400), 32'h1);
    for (int c = 0; c < 6; c++) begin
      wb_rd(8'(32 + 4 * c), mask[c] ? {16'h0, 8'hA5, 5'h0, 3'(c)} : 32'h0);
    end
    repeat (2) @(posedge clk_i);
    chk32(32'(int_n), 32'h1);
    wb_xfer(1'b1, SCSQ_OFF_CTRL, 32'h0);
    // The cycle already under way still finishes; start the next scenario from idle.
    do begin
      wb_xfer(1'b0, SCSQ_OFF_STATUS, 32'h0);
    end while (rdat[2] !== 1'b0);
  endtask : t_convert

  // A low-byte read freezes the data words across later cycles until a high-byte read.
  task automatic t_hold();
    wb_xfer(1'b1, SCSQ_OFF_CTRL, 32'h3);
    while (int_n !== 1'b0) @(posedge clk_i);
    sel <= 4'h1;
    wb_rd(SCSQ_OFF_DATA0, 32'h0);
    sel <= 4'hF;
    wb_xfer(1'b1, SCSQ_OFF_CTRL, 32'h7);
    while (int_n !== 1'b0) @(posedge clk_i);
    repeat (PER + 150) @(posedge clk_i);
    sel <= 4'h3;
    wb_rd(SCSQ_OFF_DATA0, 32'h0);
    sel <= 4'hF;
    repeat (2) @(posedge clk_i);
    wb_rd(SCSQ_OFF_DATA0, 32'h0000A500);
    wb_xfer(1'b1, SCSQ_OFF_CTRL, 32'h0);
  endtask : t_hold

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_ext_reset();
    t_led();
    t_blink();
    t_temp();
    t_convert(32'h3, 6'b011110, 1);
    dly <= 4'h7;
    t_convert(32'hF, 6'b111111, 2);
    t_hold();
    give_verdict();
  end
endmodule : tb_top
